// file: hw/lled_pkg.sv
/*
 * Shared constants, types and helpers for the LIN LED group command decoder.
 * Assumes a LIN frame layer on the same clock that hands over identifier
 * and data bytes one at a time.
 */
package lled_pkg;

    // ------------------------------------------------------------------
    // frame identifiers and data lengths
    // ------------------------------------------------------------------
    localparam logic [7:0] ID_COLOR_SHORT = 8'h6F;
    localparam logic [7:0] ID_LEVEL = 8'h2E;
    localparam logic [7:0] ID_DIAG = 8'h25;
    localparam logic [7:0] ID_CROSS = 8'h76;
    localparam logic [3:0] LEN_COLOR_SHORT = 4'h4;
    localparam logic [3:0] LEN_LEVEL = 4'h2;
    localparam logic [3:0] LEN_DIAG = 4'h4;
    localparam logic [3:0] LEN_CROSS = 4'h8;
    localparam logic [3:0] LEN_NONE = 4'h0;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ADDR_SEL_BIT = 7;
    localparam int LEVEL_GRP_LSB = 4;

    // ------------------------------------------------------------------
    // apply modes and register map
    // ------------------------------------------------------------------
    localparam logic [1:0] APPLY_NOW = 2'h0;
    localparam logic [1:0] APPLY_STORE = 2'h1;
    localparam logic [1:0] APPLY_RECALL = 2'h2;
    localparam logic [1:0] APPLY_DISCARD = 2'h3;

    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam int CTRL_CAL_EN_BIT = 0;
    localparam int CTRL_LINEAR_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef struct packed {
        logic [7:0] led1;
        logic [7:0] led2;
        logic [7:0] led3;
    } lled_rgb_s;

    typedef struct packed {
        logic [7:0] diag_coeff_1;
        logic [7:0] diag_coeff_2;
        logic [7:0] diag_coeff_3;
        logic [7:0] cross_coeff_1_2;
        logic [7:0] cross_coeff_1_3;
        logic [7:0] cross_coeff_2_1;
        logic [7:0] cross_coeff_2_3;
        logic [7:0] cross_coeff_3_1;
        logic [7:0] cross_coeff_3_2;
    } lled_coeff_s;

    typedef enum logic [1:0] {
        ST_OTP_LOAD,
        ST_IDLE,
        ST_DATA
    } lled_state_e;

    // classic checksum step: 8-bit add with end-around carry
    function automatic logic [7:0] add_wrap(input logic [7:0] a,
                                            input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0] + {7'h00, s[8]};
    endfunction

endpackage : lled_pkg

// file: hw/lled_cksum.sv
/*
 * Running classic checksum over the data bytes of one frame.
 * Assumes clear and add never come in the same cycle from the caller.
 */
module lled_cksum (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_clear,
    input wire logic i_add,
    input wire logic [7:0] i_byte,
    output logic [7:0] o_sum
);

    logic [7:0] sum_reg;
    logic [7:0] sum_next;

    // ------------------------------------------------------------------
    // accumulate
    // ------------------------------------------------------------------
    // clear wins so a new identifier always starts a fresh sum
    always_comb begin
        sum_next = sum_reg;
        if (i_clear) begin
            sum_next = lled_pkg::BYTE_RESET;
        end else if (i_add) begin
            sum_next = lled_pkg::add_wrap(sum_reg, i_byte);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            sum_reg <= lled_pkg::BYTE_RESET;
        end else begin
            sum_reg <= sum_next;
        end
    end

    assign o_sum = sum_reg;

endmodule // lled_cksum

// file: hw/lled_decoder.sv
/*
 * LIN command decoder for an RGB LED driver: short group color frames,
 * group intensity frames and correction coefficient frames.
 * Assumes the frame layer on i_mclk gives one i_id_strobe per frame, then
 * one i_rx_strobe per data byte and one for the checksum byte; OTP values
 * are static on the same clock.
 */
// Our own choices: the plain strobed port and the address map.
// What this block does
// - group addressing: act on any matching group
// - node addressing: act on own address only
// - apply mode: now, store, recall, discard
// - short color frame: three colors, group nibble
// - color group from low code bits
// - short frames always group addressed
// - intensity group from high code bits
// - intensity frame: groups, level, fade time
// - curve bit: zero log, one linear
// - diagonal frame: address, three diagonal coefficients
// - cross frame: address, six coefficients, filler
// - coefficients load from OTP after reset
// - classic checksum over data bytes verified
// - correction enable routes colors through matrix
module lled_decoder (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_id_strobe,
    input wire logic [7:0] i_id,
    input wire logic i_rx_strobe,
    input wire logic [7:0] i_rx_byte,
    input wire logic [5:0] i_node_addr,
    input wire logic [3:0] i_group_membership_code,
    input wire lled_pkg::lled_coeff_s i_otp_coeff,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output lled_pkg::lled_rgb_s o_color,
    output logic o_color_upd,
    output logic o_through_matrix,
    output logic [3:0] o_level,
    output logic [5:0] o_fade_time,
    output logic o_curve_linear,
    output logic o_level_upd,
    output lled_pkg::lled_coeff_s o_coeff
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    lled_pkg::lled_state_e state_reg, state_next;
    logic [7:0] id_reg, id_next;
    logic [3:0] idx_reg, idx_next;
    logic [7:0] buf_reg [0:7];
    logic [7:0] buf_next [0:7];
    lled_pkg::lled_rgb_s stored_reg, stored_next;
    lled_pkg::lled_rgb_s color_reg, color_next;
    logic color_upd_reg, color_upd_next;
    logic matrix_reg, matrix_next;
    logic [3:0] level_reg, level_next;
    logic [5:0] fade_reg, fade_next;
    logic linear_reg, linear_next;
    logic level_upd_reg, level_upd_next;
    lled_pkg::lled_coeff_s coeff_reg, coeff_next;
    logic [3:0] ctrl_reg, ctrl_next;
    logic [7:0] ok_cnt_reg, ok_cnt_next;
    logic [7:0] err_cnt_reg, err_cnt_next;
    logic [31:0] rdata_reg, rdata_next;

    logic [7:0] cks_sum;
    logic [3:0] exp_len;
    logic frame_end;
    logic cks_ok;
    logic color_hit;
    logic level_hit;
    logic node_hit;
    logic [1:0] apply_mode;

    // expected data byte count per identifier, zero for foreign frames
    function automatic logic [3:0] len_of(input logic [7:0] id);
        case (id)
            lled_pkg::ID_COLOR_SHORT: len_of = lled_pkg::LEN_COLOR_SHORT;
            lled_pkg::ID_LEVEL: len_of = lled_pkg::LEN_LEVEL;
            lled_pkg::ID_DIAG: len_of = lled_pkg::LEN_DIAG;
            lled_pkg::ID_CROSS: len_of = lled_pkg::LEN_CROSS;
            default: len_of = lled_pkg::LEN_NONE;
        endcase
    endfunction

    // node-or-group address check on the first data byte
    function automatic logic addr_match(input logic [7:0] d1,
                                        input logic [15:0] groups,
                                        input logic [5:0] node,
                                        input logic [3:0] code);
        if (d1[lled_pkg::ADDR_SEL_BIT]) begin
            addr_match = (d1[5:0] == node);
        end else begin
            addr_match = groups[code];
        end
    endfunction

    // ------------------------------------------------------------------
    // checksum
    // ------------------------------------------------------------------
    lled_cksum u_cksum (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_clear(i_id_strobe),
        .i_add(i_rx_strobe && state_reg == lled_pkg::ST_DATA
               && idx_reg < exp_len),
        .i_byte(i_rx_byte),
        .o_sum(cks_sum)
    );

    // ------------------------------------------------------------------
    // frame decode terms
    // ------------------------------------------------------------------
    assign exp_len = len_of(id_reg);
    assign frame_end = (state_reg == lled_pkg::ST_DATA) && i_rx_strobe
                       && !i_id_strobe && (idx_reg == exp_len)
                       && exp_len != lled_pkg::LEN_NONE;
    // data sum plus checksum byte folds to all ones when intact
    assign cks_ok = lled_pkg::add_wrap(cks_sum, i_rx_byte) == 8'hFF;
    // short frames carry no node address at all
    assign color_hit = buf_reg[3][i_group_membership_code[1:0]];
    assign level_hit = buf_reg[0][lled_pkg::LEVEL_GRP_LSB
                                  + {2'b00, i_group_membership_code[3:2]}];
    // coefficient frames carry no group bytes, so group mode never hits
    assign node_hit = addr_match(buf_reg[0], 16'h0000, i_node_addr,
                                 i_group_membership_code);
    assign apply_mode = ctrl_reg[lled_pkg::CTRL_MODE_LSB +: 2];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        id_next = id_reg;
        idx_next = idx_reg;
        for (int k = 0; k < 8; k++) begin
            buf_next[k] = buf_reg[k];
        end
        stored_next = stored_reg;
        color_next = color_reg;
        color_upd_next = 1'b0;
        matrix_next = matrix_reg;
        level_next = level_reg;
        fade_next = fade_reg;
        linear_next = linear_reg;
        level_upd_next = 1'b0;
        coeff_next = coeff_reg;
        ok_cnt_next = ok_cnt_reg;
        err_cnt_next = err_cnt_reg;
        case (state_reg)
            lled_pkg::ST_OTP_LOAD: begin
                coeff_next = i_otp_coeff;
                state_next = lled_pkg::ST_IDLE;
            end
            lled_pkg::ST_IDLE: begin
                if (i_id_strobe) begin
                    id_next = i_id;
                    idx_next = 4'h0;
                    state_next = lled_pkg::ST_DATA;
                end
            end
            lled_pkg::ST_DATA: begin
                if (i_id_strobe) begin
                    // a new header abandons a half-received frame
                    id_next = i_id;
                    idx_next = 4'h0;
                end else if (exp_len == lled_pkg::LEN_NONE) begin
                    state_next = lled_pkg::ST_IDLE;
                end else if (i_rx_strobe && idx_reg < exp_len) begin
                    buf_next[idx_reg[2:0]] = i_rx_byte;
                    idx_next = idx_reg + 4'h1;
                end else if (frame_end) begin
                    state_next = lled_pkg::ST_IDLE;
                    if (!cks_ok) begin
                        err_cnt_next = err_cnt_reg + 8'h01;
                    end else begin
                        ok_cnt_next = ok_cnt_reg + 8'h01;
                        case (id_reg)
                            lled_pkg::ID_COLOR_SHORT: begin
                                if (color_hit) begin
                                    case (apply_mode)
                                        lled_pkg::APPLY_NOW: begin
                                            color_next = {buf_reg[0],
                                                buf_reg[1], buf_reg[2]};
                                            stored_next = color_next;
                                            color_upd_next = 1'b1;
                                        end
                                        lled_pkg::APPLY_STORE: begin
                                            stored_next = {buf_reg[0],
                                                buf_reg[1], buf_reg[2]};
                                        end
                                        lled_pkg::APPLY_RECALL: begin
                                            color_next = stored_reg;
                                            color_upd_next = 1'b1;
                                        end
                                        default: begin
                                        end
                                    endcase
                                    // snapshot of the enable per matching color frame, any apply mode
                                    matrix_next = ctrl_reg[
                                        lled_pkg::CTRL_CAL_EN_BIT];
                                end
                            end
                            lled_pkg::ID_LEVEL: begin
                                if (level_hit) begin
                                    level_next = buf_reg[0][3:0];
                                    fade_next = buf_reg[1][5:0];
                                    // either curve allowed for intensity
                                    linear_next = ctrl_reg[
                                        lled_pkg::CTRL_LINEAR_BIT];
                                    level_upd_next = 1'b1;
                                end
                            end
                            lled_pkg::ID_DIAG: begin
                                if (node_hit) begin
                                    coeff_next.diag_coeff_1 = buf_reg[1];
                                    coeff_next.diag_coeff_2 = buf_reg[2];
                                    coeff_next.diag_coeff_3 = buf_reg[3];
                                end
                            end
                            lled_pkg::ID_CROSS: begin
                                if (node_hit) begin
                                    // byte eight is filler and not checked
                                    coeff_next.cross_coeff_1_2 = buf_reg[1];
                                    coeff_next.cross_coeff_1_3 = buf_reg[2];
                                    coeff_next.cross_coeff_2_1 = buf_reg[3];
                                    coeff_next.cross_coeff_2_3 = buf_reg[4];
                                    coeff_next.cross_coeff_3_1 = buf_reg[5];
                                    coeff_next.cross_coeff_3_2 = buf_reg[6];
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            default: state_next = lled_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    // unmapped reads return zero; the slave never stalls
    always_comb begin
        ctrl_next = ctrl_reg;
        rdata_next = 32'h0000_0000;
        if (i_wr && i_addr == lled_pkg::REG_CTRL) begin
            ctrl_next = i_wdata[3:0];
        end
        if (i_rd) begin
            case (i_addr)
                lled_pkg::REG_CTRL: rdata_next = {28'h000_0000, ctrl_reg};
                lled_pkg::REG_STATUS: begin
                    rdata_next = {16'h0000, err_cnt_reg, ok_cnt_reg};
                end
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            state_reg <= lled_pkg::ST_OTP_LOAD;
            id_reg <= lled_pkg::BYTE_RESET;
            idx_reg <= 4'h0;
            for (int k = 0; k < 8; k++) begin
                buf_reg[k] <= lled_pkg::BYTE_RESET;
            end
            stored_reg <= '0;
            color_reg <= '0;
            color_upd_reg <= 1'b0;
            matrix_reg <= 1'b0;
            level_reg <= 4'h0;
            fade_reg <= 6'h00;
            linear_reg <= 1'b0;
            level_upd_reg <= 1'b0;
            coeff_reg <= '0;
            ctrl_reg <= lled_pkg::CTRL_RESET;
            ok_cnt_reg <= lled_pkg::CNT_RESET;
            err_cnt_reg <= lled_pkg::CNT_RESET;
            rdata_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            id_reg <= id_next;
            idx_reg <= idx_next;
            for (int k = 0; k < 8; k++) begin
                buf_reg[k] <= buf_next[k];
            end
            stored_reg <= stored_next;
            color_reg <= color_next;
            color_upd_reg <= color_upd_next;
            matrix_reg <= matrix_next;
            level_reg <= level_next;
            fade_reg <= fade_next;
            linear_reg <= linear_next;
            level_upd_reg <= level_upd_next;
            coeff_reg <= coeff_next;
            ctrl_reg <= ctrl_next;
            ok_cnt_reg <= ok_cnt_next;
            err_cnt_reg <= err_cnt_next;
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_color = color_reg;
    assign o_color_upd = color_upd_reg;
    assign o_through_matrix = matrix_reg;
    assign o_level = level_reg;
    assign o_fade_time = fade_reg;
    assign o_curve_linear = linear_reg;
    assign o_level_upd = level_upd_reg;
    assign o_coeff = coeff_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    logic short_end;
    assign short_end = frame_end && cks_ok
                       && id_reg == lled_pkg::ID_COLOR_SHORT && color_hit;

    otp_load_a: assert property (state_reg == lled_pkg::ST_OTP_LOAD
        |=> o_coeff == $past(i_otp_coeff) && state_reg == lled_pkg::ST_IDLE)
        else $error("coefficients not loaded from otp");
    bad_cks_hold_a: assert property (frame_end && !cks_ok
        |=> $stable(o_color) && $stable(o_coeff) && $stable(o_level)
            && !o_color_upd && !o_level_upd)
        else $error("bad checksum changed state");
    color_now_a: assert property (short_end && apply_mode == 2'h0
        |=> o_color_upd && o_color.led1 == $past(buf_reg[0])
            && o_color.led3 == $past(buf_reg[2]))
        else $error("immediate color not applied");
    color_store_a: assert property (short_end && apply_mode == 2'h1
        |=> stored_reg.led2 == $past(buf_reg[1]) && !o_color_upd
            && $stable(o_color))
        else $error("stored color not kept apart");
    color_recall_a: assert property (short_end && apply_mode == 2'h2
        |=> o_color == $past(stored_reg) && o_color_upd)
        else $error("stored color not recalled");
    color_discard_a: assert property (short_end && apply_mode == 2'h3
        |=> $stable(o_color) && $stable(stored_reg) && !o_color_upd)
        else $error("discarded color was used");
    color_miss_a: assert property (frame_end
        && id_reg == lled_pkg::ID_COLOR_SHORT && !color_hit
        |=> !o_color_upd && $stable(o_color))
        else $error("color frame acted on foreign group");
    matrix_flag_a: assert property (short_end
        |=> o_through_matrix == $past(ctrl_reg[0]))
        else $error("matrix route not taken from enable");
    level_hit_a: assert property (frame_end && cks_ok
        && id_reg == lled_pkg::ID_LEVEL && level_hit
        |=> o_level_upd && o_level == $past(buf_reg[0][3:0])
            && o_fade_time == $past(buf_reg[1][5:0])
            && o_curve_linear == $past(ctrl_reg[1]))
        else $error("intensity frame misdecoded");
    level_miss_a: assert property (frame_end
        && id_reg == lled_pkg::ID_LEVEL && !level_hit
        |=> !o_level_upd && $stable(o_level))
        else $error("intensity frame acted on foreign group");
    diag_node_a: assert property (frame_end && cks_ok
        && id_reg == lled_pkg::ID_DIAG
        |=> (o_coeff.diag_coeff_2 == $past(buf_reg[2]))
            == $past(node_hit) || $past(coeff_reg.diag_coeff_2)
            == $past(buf_reg[2]))
        else $error("diagonal coefficient load wrong");
    cross_load_a: assert property (frame_end && cks_ok
        && id_reg == lled_pkg::ID_CROSS && node_hit
        |=> o_coeff.cross_coeff_3_2 == $past(buf_reg[6])
            && o_coeff.cross_coeff_1_2 == $past(buf_reg[1]))
        else $error("cross coefficient load wrong");

    color_cov_c: cover property (short_end ##1 o_color_upd);
    level_cov_c: cover property (o_level_upd);
    cross_cov_c: cover property (frame_end && cks_ok
        && id_reg == lled_pkg::ID_CROSS && node_hit);
    err_cov_c: cover property (frame_end && !cks_ok);

endmodule // lled_decoder

// file: sim/lled_lin_master.sv
/*
 * LIN master model: sends one frame as id strobe, data strobes, checksum.
 * Assumes the decoder samples its frame inputs on the rising i_mclk edge.
 */
module lled_lin_master (
    input wire logic i_mclk,
    output logic o_id_strobe,
    output logic [7:0] o_id,
    output logic o_rx_strobe,
    output logic [7:0] o_rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus, nothing strobed
    initial begin
        o_id_strobe = 1'b0;
        o_id = 8'h00;
        o_rx_strobe = 1'b0;
        o_rx_byte = 8'h00;
    end

    // bad flips one checksum bit to model a line error; colour frames
    // carry no curve bit, so the linear duty is kept trivially
    task automatic send(input logic [7:0] id, input logic [63:0] d,
                        input int n, input logic bad);
        logic [8:0] t;
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < n; i++) begin
            t = {1'b0, s} + {1'b0, d[63-8*i -: 8]};
            s = t[7:0] + {7'h00, t[8]};
        end
        s = ~s ^ {7'h00, bad};
        @(posedge i_mclk);
        o_id_strobe <= 1'b1;
        o_id <= id;
        for (int i = 0; i < n; i++) begin
            @(posedge i_mclk);
            o_id_strobe <= 1'b0;
            o_id <= ~id;
            o_rx_strobe <= 1'b1;
            o_rx_byte <= d[63-8*i -: 8];
        end
        @(posedge i_mclk);
        o_rx_byte <= s;
        @(posedge i_mclk);
        o_rx_strobe <= 1'b0;
        o_rx_byte <= ~s; // released byte must not look stale
        #1;
    endtask
endmodule // lled_lin_master

// file: sim/lled_decoder_bench.sv
/*
 * Self-checking bench for the LIN LED command decoder.
 * Assumes one 40 MHz clock and static OTP node, group and coefficients.
 */
module lled_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, srst, ids, rxs, wr, rd;
    logic [7:0] id, rxb;
    logic [3:0] addr;
    logic [31:0] wdata, rdata;
    lled_pkg::lled_rgb_s color;
    lled_pkg::lled_coeff_s coeff;
    logic cupd, thru, lin, lupd;
    logic [3:0] lvl;
    logic [5:0] fade;
    int bad_count = 0;
    int cmp_count = 0;
    localparam logic [71:0] OTP = 72'h0102_0304_0506_0708_09;

    lled_decoder dut (.i_mclk(clk), .i_srst(srst), .i_id_strobe(ids),
        .i_id(id), .i_rx_strobe(rxs), .i_rx_byte(rxb),
        .i_node_addr(6'h15), .i_group_membership_code(4'h6),
        .i_otp_coeff(OTP), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .o_color(color), .o_color_upd(cupd),
        .o_through_matrix(thru), .o_level(lvl), .o_fade_time(fade),
        .o_curve_linear(lin), .o_level_upd(lupd), .o_coeff(coeff));
    lled_lin_master mst (.i_mclk(clk), .o_id_strobe(ids), .o_id(id),
        .o_rx_strobe(rxs), .o_rx_byte(rxb));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic stop_test;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // watchdog: the tests need well under 1000 cycles
    initial begin
        #(25 * 5000);
        bad_count++;
        stop_test();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        srst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(coeff, OTP);
        mst.send(8'h6F, 64'h1122_33F4_0000_0000, 4, 1'b0);
        chk({cupd, color}, 25'h111_2233);
        mst.send(8'h6F, 64'h4455_66F1_0000_0000, 4, 1'b0);
        chk({cupd, color}, 25'h011_2233);
        mst.send(8'h6F, 64'h4455_66F4_0000_0000, 4, 1'b1);
        chk({cupd, color}, 25'h011_2233);
        wreg(4'h0, 32'h0000_0005); // store mode, correction on
        mst.send(8'h6F, 64'h4455_66FC_0000_0000, 4, 1'b0);
        chk(color, 24'h11_2233);
        wreg(4'h0, 32'h0000_0009); // recall mode
        mst.send(8'h6F, 64'h7777_77F4_0000_0000, 4, 1'b0);
        chk({thru, color}, 25'h144_5566);
        wreg(4'h0, 32'h0000_000C); // discard mode
        mst.send(8'h6F, 64'h9999_99F4_0000_0000, 4, 1'b0);
        chk(color, 24'h44_5566);
        wreg(4'h0, 32'h0000_0002);
        mst.send(8'h2E, 64'h25C3_0000_0000_0000, 2, 1'b0);
        chk({lupd, lin, fade, lvl}, 12'hC35);
        wreg(4'h0, 32'h0000_0000);
        mst.send(8'h2E, 64'h1AC7_0000_0000_0000, 2, 1'b0);
        chk({lupd, lin, fade, lvl}, 12'h435);
        mst.send(8'h2E, 64'h2AC7_0000_0000_0000, 2, 1'b0);
        chk({lupd, lin, fade, lvl}, 12'h87A);
        mst.send(8'h25, 64'hD4A1_A2A3_0000_0000, 4, 1'b0);
        mst.send(8'h25, 64'h55A1_A2A3_0000_0000, 4, 1'b0);
        chk(coeff, OTP);
        mst.send(8'h25, 64'hD5A1_A2A3_0000_0000, 4, 1'b0);
        chk(coeff, 72'hA1A2_A304_0506_0708_09);
        mst.send(8'h76, 64'hD5B1_B2B3_B4B5_B6FF, 8, 1'b0);
        chk(coeff, 72'hA1A2_A3B1_B2B3_B4B5_B6);
        rreg(4'h4, 32'h0000_010C);
        rreg(4'h8, 32'h0000_0000);
        wreg(4'h0, 32'h0000_00FF);
        rreg(4'h0, 32'h0000_000F);
        // a second reset must bring the coefficients back from otp
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(coeff, OTP);
        stop_test();
    end
endmodule // lled_decoder_bench
